// ==== hdl/pat_pkg.sv ====
// Package with register map, field positions, reset values and state type of the PWM auto-reload timer
package pat_pkg;

    localparam int          ADDR_W        = 12;
    localparam int          DATA_W        = 32;
    localparam int          NUM_PWM       = 4;
    localparam int          NUM_CAP       = 2;

    // Register indices as printed; byte address is four times the index
    localparam logic [9:0]  IDX_DUTY3     = 10'h073;
    localparam logic [9:0]  IDX_DUTY2     = 10'h074;
    localparam logic [9:0]  IDX_DUTY1     = 10'h075;
    localparam logic [9:0]  IDX_DUTY0     = 10'h076;
    localparam logic [9:0]  IDX_PWMCTL    = 10'h077;
    localparam logic [9:0]  IDX_CSR       = 10'h078;
    localparam logic [9:0]  IDX_CAR       = 10'h079;
    localparam logic [9:0]  IDX_ARR       = 10'h07a;
    localparam logic [9:0]  IDX_ICCSR     = 10'h07b;
    localparam logic [9:0]  IDX_ICR1      = 10'h07c;
    localparam logic [9:0]  IDX_ICR2      = 10'h07d;

    // Control/status field positions
    localparam int          CSR_CLOCK_SOURCE_SELECT      = 7;
    localparam int          CSR_CC_HI     = 6;
    localparam int          CSR_CC_LO     = 4;
    localparam int          CSR_TCE       = 3;
    localparam int          CSR_FORCE_RELOAD      = 2;
    localparam int          CSR_OIE       = 1;
    localparam int          CSR_OVF       = 0;

    // Output control: enables in high nibble, polarities in low nibble
    localparam int          PWM_OE_LO     = 4;
    localparam int          PWM_OP_LO     = 0;

    // Capture control/status field positions
    localparam int          ICS_CS_LO     = 4;
    localparam int          ICS_CIE_LO    = 2;
    localparam int          ICS_CF_LO     = 0;

    localparam logic [7:0]  REG8_RST      = 8'h00;
    localparam logic [6:0]  PRESC_RST     = 7'h00;
    localparam logic [7:0]  CNT_TOP       = 8'hff;
    localparam logic [6:0]  PRESC_ONE     = 7'h01;
    localparam logic [7:0]  CNT_ONE       = 8'h01;

    typedef struct packed {
        logic [7:0]                  cnt;
        logic [6:0]                  presc;
        logic [7:0]                  arr;
        logic [NUM_PWM-1:0][7:0]     duty;
        logic [NUM_PWM-1:0][7:0]     ocr;
        logic [7:0]                  pwmctl;
        logic                        clock_source_select;
        logic [2:0]                  cc;
        logic                        count_enable_bit;
        logic                        overflow_irq_enable;
        logic                        ovf;
        logic [NUM_CAP-1:0]          cs;
        logic [NUM_CAP-1:0]          cie;
        logic [NUM_CAP-1:0]          cf;
        logic [NUM_CAP-1:0][7:0]     icr;
        logic [2:0]                  ext_s;
        logic [NUM_CAP-1:0][2:0]     cap_s;
        logic [NUM_PWM-1:0]          raw;
        logic [NUM_PWM-1:0]          pin;
        logic                        ovf_irq;
        logic [NUM_CAP-1:0]          cap_irq;
        logic                        wake;
        logic [DATA_W-1:0]           prdata;
    } pat_state_t;

endpackage

// ==== hdl/pat_timer.sv ====
// PWM auto-reload timer with prescaler, four PWM outputs, overflow flag and two input captures
`timescale 1ns/10ps

// Functional notes
// - 8-bit counter increments on each prescaler output tick.
// - Counter readable and writable on the fly through the counter access register.
// - On overflow the counter loads the reload value; prescaler is untouched.
// - 7-bit prescaler, select code n divides by two to the n.
// - Clock source select 0 picks CPU clock, 1 picks external clock.
// - Count enable low freezes prescaler and counter; high lets them run.
// - Reset clears counter, prescaler and control/status; CPU clock selected.
// - Force reload with enable, or counter write, clears the prescaler.
// - Four hidden compare values reload from duty registers at every overflow.
// - Output enable bit per channel drives that pin push-pull.
// - Common PWM period is counter period times 256 minus reload.
// - Overflow sets pin to inverse of polarity bit; compare match sets it to polarity level.
// - Overflow sets the flag; interrupt requested when its enable is set.
// - Event mode: flag sets after 256 minus reload external events.
// - Selected capture edge copies counter into capture register and sets flag.
// - Capture register blocked after a capture until software reads it.
// - Capture interrupt held while flag and its enable are both set.
// - Rising or falling trigger edge chosen per capture channel.
// - During halt an enabled capture interrupt still wakes the processor.
// - Reading the control/status register clears the overflow flag.
// - Force reload bit is write-only and reads as zero.
// - Edge select 0 means falling edge, 1 means rising edge.
// - Reading a capture value register clears that channel's flag.
module pat_timer
    import pat_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [ADDR_W-1:0]    paddr,
    input  wire logic [DATA_W-1:0]    pwdata,
    output logic      [DATA_W-1:0]    prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 ext_clock_in,
    input  wire logic [NUM_CAP-1:0]   capture_pin_x,
    input  wire logic                 halt_mode,
    output logic      [NUM_PWM-1:0]   pwm_pin_x,
    output logic      [NUM_PWM-1:0]   pwm_pin_oe,
    output logic                      overflow_irq,
    output logic      [NUM_CAP-1:0]   capture_irq,
    output logic                      wake_req
);

    pat_state_t          s_r;
    pat_state_t          s_nxt;

    logic [9:0]          idx;
    logic                mapped;
    logic                acc;
    logic                wr;
    logic                rd;
    logic                ext_rise;
    logic                in_tick;
    logic                run;
    logic [6:0]          tap_mask;
    logic                cnt_tick;
    logic                ovf_tick;
    logic                wr_car;
    logic                force_ld;
    logic                csr_rd;
    logic [NUM_CAP-1:0]  cap_edge;
    logic [NUM_CAP-1:0]  icr_rd;
    logic [7:0]          rmux;

    assign idx    = paddr[ADDR_W-1:2];
    assign mapped = (paddr[1:0] == 2'b00) && (idx >= IDX_DUTY3) && (idx <= IDX_ICR2);
    // Zero-wait slave; read data was latched in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    always_comb begin
        rmux = REG8_RST;
        case (idx)
            IDX_DUTY3:  rmux = s_r.duty[3];
            IDX_DUTY2:  rmux = s_r.duty[2];
            IDX_DUTY1:  rmux = s_r.duty[1];
            IDX_DUTY0:  rmux = s_r.duty[0];
            IDX_PWMCTL: rmux = s_r.pwmctl;
            // Force reload reads back as zero
            IDX_CSR:    rmux = {s_r.clock_source_select, s_r.cc, s_r.count_enable_bit, 1'b0, s_r.overflow_irq_enable, s_r.ovf};
            IDX_CAR:    rmux = s_r.cnt;
            IDX_ARR:    rmux = s_r.arr;
            IDX_ICCSR:  rmux = {2'b00, s_r.cs, s_r.cie, s_r.cf};
            IDX_ICR1:   rmux = s_r.icr[0];
            IDX_ICR2:   rmux = s_r.icr[1];
            default:    rmux = REG8_RST;
        endcase
    end

    always_comb begin
        s_nxt    = s_r;
        acc      = psel && penable;
        wr       = acc && pwrite && mapped;
        rd       = acc && !pwrite && mapped;
        csr_rd   = rd && (idx == IDX_CSR);
        wr_car   = wr && (idx == IDX_CAR);
        force_ld = wr && (idx == IDX_CSR) && pwdata[CSR_FORCE_RELOAD] && pwdata[CSR_TCE];

        // Only the second and third stages feed any logic
        s_nxt.ext_s = {s_r.ext_s[1:0], ext_clock_in};
        ext_rise    = s_r.ext_s[1] && !s_r.ext_s[2];
        in_tick     = s_r.clock_source_select ? ext_rise : 1'b1;
        run         = s_r.count_enable_bit && in_tick;
        tap_mask    = 7'((8'h01 << s_r.cc) - 8'h01);
        cnt_tick    = run && ((s_r.presc & tap_mask) == tap_mask);
        ovf_tick    = cnt_tick && (s_r.cnt == CNT_TOP);

        // Prescaler: no direct access, cleared by counter write or forced reload
        if (wr_car || force_ld) begin
            s_nxt.presc = PRESC_RST;
        end else if (run) begin
            s_nxt.presc = s_r.presc + PRESC_ONE;
        end

        if (wr_car) begin
            s_nxt.cnt = pwdata[7:0];
        end else if (force_ld) begin
            s_nxt.cnt = s_r.arr;
        end else if (ovf_tick) begin
            s_nxt.cnt = s_r.arr;
        end else if (cnt_tick) begin
            s_nxt.cnt = s_r.cnt + CNT_ONE;
        end

        // Set wins over the read clear so no overflow is lost
        s_nxt.ovf = ovf_tick || (s_r.ovf && !csr_rd);

        if (wr && (idx == IDX_CSR)) begin
            s_nxt.clock_source_select = pwdata[CSR_CLOCK_SOURCE_SELECT];
            s_nxt.cc   = pwdata[CSR_CC_HI:CSR_CC_LO];
            s_nxt.count_enable_bit  = pwdata[CSR_TCE];
            s_nxt.overflow_irq_enable  = pwdata[CSR_OIE];
        end
        if (wr && (idx == IDX_ARR)) begin
            s_nxt.arr = pwdata[7:0];
        end
        if (wr && (idx == IDX_PWMCTL)) begin
            s_nxt.pwmctl = pwdata[7:0];
        end
        if (wr && (idx == IDX_ICCSR)) begin
            s_nxt.cs  = pwdata[ICS_CS_LO +: NUM_CAP];
            s_nxt.cie = pwdata[ICS_CIE_LO +: NUM_CAP];
        end

        for (int i = 0; i < NUM_PWM; i++) begin
            if (wr && (idx == 10'(IDX_DUTY0 - 10'(i)))) begin
                s_nxt.duty[i] = pwdata[7:0];
            end
            // Double buffering keeps a duty change glitch free
            if (ovf_tick) begin
                s_nxt.ocr[i] = s_r.duty[i];
                s_nxt.raw[i] = 1'b1;
            end else if (cnt_tick && (s_r.cnt == s_r.ocr[i])) begin
                s_nxt.raw[i] = 1'b0;
            end
            // Polarity flip takes effect at once, not at the next period
            s_nxt.pin[i] = s_nxt.pwmctl[PWM_OE_LO + i] && (s_nxt.raw[i] ^ s_nxt.pwmctl[PWM_OP_LO + i]);
        end

        for (int i = 0; i < NUM_CAP; i++) begin
            s_nxt.cap_s[i] = {s_r.cap_s[i][1:0], capture_pin_x[i]};
            cap_edge[i]    = s_r.cs[i] ? (s_r.cap_s[i][1] && !s_r.cap_s[i][2])
                                       : (!s_r.cap_s[i][1] && s_r.cap_s[i][2]);
            icr_rd[i]      = rd && (idx == 10'(IDX_ICR1 + 10'(i)));
            // A new edge in the clearing read cycle is kept
            if (cap_edge[i] && (!s_r.cf[i] || icr_rd[i])) begin
                s_nxt.icr[i] = s_r.cnt;
                s_nxt.cf[i]  = 1'b1;
            end else if (icr_rd[i]) begin
                s_nxt.cf[i] = 1'b0;
            end
        end

        s_nxt.ovf_irq = s_nxt.ovf && s_nxt.overflow_irq_enable;
        s_nxt.cap_irq = s_nxt.cf & s_nxt.cie;
        // Capture logic stays on the timer clock, so it can wake from halt
        s_nxt.wake    = halt_mode && (|s_nxt.cap_irq);

        if (psel && !penable) begin
            s_nxt.prdata = {24'h000000, rmux};
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata       = s_r.prdata;
    assign pwm_pin_x    = s_r.pin;
    assign pwm_pin_oe   = s_r.pwmctl[PWM_OE_LO +: NUM_PWM];
    assign overflow_irq = s_r.ovf_irq;
    assign capture_irq  = s_r.cap_irq;
    assign wake_req     = s_r.wake;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    AST_CNT_INC: assert property (cnt_tick && (s_r.cnt != CNT_TOP) && !wr_car && !force_ld
        |=> s_r.cnt == $past(s_r.cnt) + CNT_ONE) else $error("counter did not advance by one");

    AST_CAR_WRITE: assert property (wr_car |=> (s_r.cnt == $past(pwdata[7:0])) && (s_r.presc == PRESC_RST))
        else $error("counter access write not applied");

    AST_OVF_RELOAD: assert property (ovf_tick && !wr_car && !force_ld
        |=> (s_r.cnt == $past(s_r.arr)) && (s_r.presc == $past(s_r.presc) + PRESC_ONE))
        else $error("overflow reload wrong or prescaler disturbed");

    AST_DIV_ONE: assert property (s_r.count_enable_bit && !s_r.clock_source_select && (s_r.cc == 3'b000) |-> cnt_tick)
        else $error("divide by one missed a tick");

    AST_FREEZE: assert property (!s_r.count_enable_bit && !wr_car && !wr
        |=> $stable(s_r.cnt) && $stable(s_r.presc)) else $error("counter moved while disabled");

    AST_RESET: assert property (disable iff (1'b0) $past(rst) |-> (s_r.cnt == REG8_RST) && (s_r.presc == PRESC_RST)
        && !s_r.clock_source_select && !s_r.count_enable_bit && !s_r.ovf) else $error("reset state wrong");

    AST_FORCE: assert property (force_ld && !wr_car |=> (s_r.cnt == $past(s_r.arr)) && (s_r.presc == PRESC_RST))
        else $error("forced reload wrong");

    AST_OCR_LOAD: assert property (ovf_tick |=> s_r.ocr == $past(s_r.duty))
        else $error("compare values not reloaded");

    AST_PWM_LEVEL: assert property (ovf_tick && s_r.pwmctl[PWM_OE_LO] && !(wr && (idx == IDX_PWMCTL))
        |=> s_r.pin[0] == !s_r.pwmctl[PWM_OP_LO]) else $error("pwm level after overflow wrong");

    AST_OVF_FLAG: assert property (ovf_tick |=> s_r.ovf ##1 (s_r.ovf_irq == (s_r.ovf && s_r.overflow_irq_enable)))
        else $error("overflow flag or interrupt wrong");

    AST_OVF_CLR: assert property (csr_rd && !ovf_tick |=> !s_r.ovf)
        else $error("status read did not clear overflow");

    AST_FORCE_RELOAD_ZERO: assert property (psel && !penable && (idx == IDX_CSR) |=> !prdata[CSR_FORCE_RELOAD])
        else $error("force reload bit read as one");

    AST_CAP_HOLD: assert property (s_r.cf[0] && !icr_rd[0] |=> $stable(s_r.icr[0]) && s_r.cf[0])
        else $error("capture register changed while blocked");

    AST_CAP_TAKE: assert property (cap_edge[1] && !s_r.cf[1] |=> s_r.cf[1] && (s_r.icr[1] == $past(s_r.cnt)))
        else $error("capture not taken");

    AST_CAP_CLR: assert property (icr_rd[0] && !cap_edge[0] |=> !s_r.cf[0])
        else $error("capture flag not cleared by read");

    AST_CAP_IRQ: assert property (s_r.cf[1] && s_r.cie[1] |=> s_r.cap_irq[1] || !s_r.cf[1] || !s_r.cie[1])
        else $error("capture interrupt dropped");

    AST_EXT_SRC: assert property (s_r.count_enable_bit && s_r.clock_source_select && !ext_rise
        |-> !cnt_tick)
        else $error("external source ticked without an edge");

    AST_CPU_SRC: assert property (s_r.count_enable_bit && !s_r.clock_source_select && !wr_car && !force_ld
        |=> s_r.presc == $past(s_r.presc) + PRESC_ONE)
        else $error("prescaler did not follow cpu clock");

    AST_TAP_TWO: assert property (s_r.count_enable_bit && !s_r.clock_source_select && (s_r.cc == 3'b001) && !s_r.presc[0]
        |-> !cnt_tick)
        else $error("divide by two ticked early");

    AST_CC_WRITE: assert property (wr && (idx == IDX_CSR)
        |=> {s_r.clock_source_select, s_r.cc, s_r.count_enable_bit, s_r.overflow_irq_enable} == {$past(pwdata[7:3]), $past(pwdata[1])})
        else $error("control write not applied");

    AST_NO_TICK_OFF: assert property (!s_r.count_enable_bit
        |-> !cnt_tick && !ovf_tick)
        else $error("tick while counting disabled");

    AST_ARR_WRITE: assert property (wr && (idx == IDX_ARR)
        |=> s_r.arr == $past(pwdata[7:0]))
        else $error("reload write not applied");

    AST_DUTY_WRITE: assert property (wr && (idx == IDX_DUTY0)
        |=> s_r.duty[0] == $past(pwdata[7:0]))
        else $error("duty write not applied");

    AST_OCR_HOLD: assert property (!ovf_tick
        |=> $stable(s_r.ocr))
        else $error("compare value changed between overflows");

    AST_PIN_OFF: assert property (!s_r.pwmctl[PWM_OE_LO + 1] && !(wr && (idx == IDX_PWMCTL))
        |=> !s_r.pin[1])
        else $error("disabled channel drives a level");

    AST_PIN_MATCH: assert property (cnt_tick && !ovf_tick && (s_r.cnt == s_r.ocr[1])
        && s_r.pwmctl[PWM_OE_LO + 1] && !(wr && (idx == IDX_PWMCTL))
        |=> s_r.pin[1] == s_r.pwmctl[PWM_OP_LO + 1])
        else $error("pwm level after compare wrong");

    AST_OVF_KEEP: assert property (s_r.ovf && !csr_rd
        |=> s_r.ovf)
        else $error("overflow flag cleared by itself");

    AST_OVF_SET_WINS: assert property (ovf_tick && csr_rd
        |=> s_r.ovf)
        else $error("overflow lost against status read");

    AST_NO_OVF_FLAG: assert property (!ovf_tick && !s_r.ovf
        |=> !s_r.ovf)
        else $error("overflow flag set without overflow");

    AST_OVF_IRQ_OFF: assert property (!s_r.overflow_irq_enable && !(wr && (idx == IDX_CSR))
        |=> !s_r.ovf_irq)
        else $error("overflow interrupt while disabled");

    AST_EVT_TICK: assert property (s_r.count_enable_bit && s_r.clock_source_select && (s_r.cc == 3'b000) && ext_rise
        |-> cnt_tick)
        else $error("external event not counted");

    AST_ICR_RO: assert property (wr && (idx == IDX_ICR1) && !cap_edge[0]
        |=> $stable(s_r.icr[0]))
        else $error("capture register written by software");

    AST_CAP_BLOCK_SET: assert property (cap_edge[0] && icr_rd[0]
        |=> s_r.cf[0])
        else $error("capture lost against clearing read");

    AST_CAP_FALL: assert property (s_r.cap_s[0][2] && !s_r.cap_s[0][1] && !s_r.cs[0] && !s_r.cf[0]
        |=> s_r.cf[0])
        else $error("falling edge capture missed");

    AST_CAP_RISE_IGN: assert property (!s_r.cap_s[1][2] && s_r.cap_s[1][1] && !s_r.cs[1] && !s_r.cf[1]
        |=> !s_r.cf[1])
        else $error("rising edge captured in falling mode");

    AST_CAP_CLR1: assert property (icr_rd[1] && !cap_edge[1]
        |=> !s_r.cf[1])
        else $error("second capture flag not cleared by read");

    AST_CAP_IRQ_OFF: assert property (!s_r.cie[0] && !(wr && (idx == IDX_ICCSR))
        |=> !s_r.cap_irq[0])
        else $error("capture interrupt while disabled");

    AST_WAKE: assert property (halt_mode && s_r.cf[0] && s_r.cie[0] && !icr_rd[0]
        && !(wr && (idx == IDX_ICCSR))
        |=> s_r.wake)
        else $error("capture interrupt did not wake");

    AST_NO_WAKE: assert property (!halt_mode
        |=> !s_r.wake)
        else $error("wake request outside halt");

    AST_SYNC_EXT: assert property (1'b1
        |=> s_r.ext_s[2:1] == $past(s_r.ext_s[1:0]))
        else $error("external clock synchroniser broken");

    AST_SYNC_CAP: assert property (1'b1
        |=> s_r.cap_s[1][2:1] == $past(s_r.cap_s[1][1:0]))
        else $error("capture synchroniser broken");

    COV_OVF:     cover property (ovf_tick ##1 s_r.ovf_irq);
    COV_EVENT:   cover property (s_r.clock_source_select && ovf_tick);
    COV_CAPTURE: cover property (cap_edge[0] && !s_r.cf[0] ##1 s_r.cf[0]);
    COV_PWM:     cover property ($rose(s_r.pin[0]) ##[1:600] $fell(s_r.pin[0]));
    COV_WAKE:    cover property (halt_mode && s_r.wake);

endmodule

// ==== bench/pat_pins_model.sv ====
// Model of the external clock and capture pins facing the timer
`timescale 1ns/10ps
module pat_pins_model
    import pat_pkg::*;
(
    input  wire logic               clock,
    output logic                    ext_clock_in,
    output logic [NUM_CAP-1:0]      capture_pin_x
);
    initial begin
        ext_clock_in  = 1'b0;
        capture_pin_x = '0;
    end

    // Pulses wider than the two-flop synchroniser, clock idles low
    task automatic ext_pulses(input int n);
        repeat (n) begin
            @(posedge clock);
            ext_clock_in <= 1'b1;
            repeat (4) @(posedge clock);
            ext_clock_in <= 1'b0;
            repeat (4) @(posedge clock);
        end
    endtask

    // Slow pin change, then time for sync, detect and flag
    task automatic set_pin(input int ch, input logic v);
        @(posedge clock);
        capture_pin_x[ch] <= v;
        repeat (8) @(posedge clock);
    endtask
endmodule

// ==== bench/tb.sv ====
// Self-checking testbench of the PWM auto-reload timer
`timescale 1ns/10ps
module tb
    import pat_pkg::*;
;
    logic                 clock, rst, psel, penable, pwrite, halt_mode;
    logic [ADDR_W-1:0]    paddr;
    logic [DATA_W-1:0]    pwdata, prdata, rdv;
    logic                 pready, pslverr, errv, ext_clock_in, overflow_irq, wake_req;
    logic [NUM_CAP-1:0]   capture_pin_x, capture_irq;
    logic [NUM_PWM-1:0]   pwm_pin_x, pwm_pin_oe;
    int                   n_errors = 0;
    int                   total_checks = 0;
    int                   hi, per;

    pat_timer i_pat_timer (
        .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_clock_in(ext_clock_in), .capture_pin_x(capture_pin_x), .halt_mode(halt_mode),
        .pwm_pin_x(pwm_pin_x), .pwm_pin_oe(pwm_pin_oe), .overflow_irq(overflow_irq),
        .capture_irq(capture_irq), .wake_req(wake_req)
    );

    pat_pins_model i_pat_pins_model (
        .clock(clock), .ext_clock_in(ext_clock_in), .capture_pin_x(capture_pin_x)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] got);
        total_checks++;
        if (got !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, got);
        end
    endtask

    // Request held until pready is sampled high
    task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h000000, d};
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rdv = prdata;
        errv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask

    task automatic rd(input logic [9:0] idx, input logic [7:0] e, input string nm);
        apb(1'b0, idx, 8'h00);
        chk(nm, {24'h000000, e}, rdv);
    endtask

    // Skips two rises so the compare value is already reloaded
    task automatic meas();
        hi = 0;
        per = 0;
        repeat (2) begin
            while (pwm_pin_x[0] !== 1'b0) @(posedge clock);
            while (pwm_pin_x[0] !== 1'b1) @(posedge clock);
        end
        while (pwm_pin_x[0] === 1'b1) begin
            hi++;
            per++;
            @(posedge clock);
        end
        while (pwm_pin_x[0] !== 1'b1) begin
            per++;
            @(posedge clock);
        end
    endtask

    task automatic print_verdict();
        if (n_errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clock);
        n_errors++;
        print_verdict();
    end

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        halt_mode = 1'b0;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 11; i++) begin
            rd(IDX_DUTY3 + i[9:0], 8'h00, "reset value");
        end
        apb(1'b0, 10'h3ff, 8'h00);
        chk("unmapped error", 32'h1, {31'h0, errv});
        chk("unmapped data", 32'h0, rdv);
        wr(IDX_CAR, 8'h10);
        repeat (20) @(posedge clock);
        rd(IDX_CAR, 8'h10, "frozen counter");
        wr(IDX_ARR, 8'h55);
        wr(IDX_CSR, 8'h7c);
        wr(IDX_CSR, 8'h06);
        rd(IDX_CAR, 8'h55, "forced reload");
        rd(IDX_CSR, 8'h02, "force bit reads zero");
        wr(IDX_ARR, 8'hf0);
        wr(IDX_DUTY0, 8'hf8);
        wr(IDX_PWMCTL, 8'h10);
        repeat (3) @(posedge clock);
        chk("output enable", 32'h1, {28'h0, pwm_pin_oe});
        for (int c = 0; c < 8; c++) begin
            wr(IDX_CSR, {1'b0, c[2:0], 4'hc});
            meas();
            chk("pwm period", 16 << c, per);
            chk("pwm high", 9 << c, hi);
            chk("idle channel", 32'h0, {31'h0, pwm_pin_x[1]});
        end
        wr(IDX_PWMCTL, 8'h11);
        wr(IDX_CSR, 8'h0c);
        meas();
        chk("inverted high", 32'h7, hi);
        wr(IDX_CSR, 8'h02);
        repeat (20) @(posedge clock);
        chk("overflow irq", 32'h1, {31'h0, overflow_irq});
        rd(IDX_CSR, 8'h03, "status with flag");
        rd(IDX_CSR, 8'h02, "status after read");
        repeat (3) @(posedge clock);
        chk("overflow irq off", 32'h0, {31'h0, overflow_irq});
        wr(IDX_ARR, 8'hfd);
        wr(IDX_CAR, 8'hfd);
        wr(IDX_CSR, 8'h88);
        i_pat_pins_model.ext_pulses(2);
        repeat (6) @(posedge clock);
        rd(IDX_CAR, 8'hff, "event count");
        rd(IDX_CSR, 8'h88, "no overflow yet");
        i_pat_pins_model.ext_pulses(1);
        repeat (6) @(posedge clock);
        rd(IDX_CSR, 8'h89, "event overflow");
        rd(IDX_CAR, 8'hfd, "event reload");
        wr(IDX_CSR, 8'h00);
        wr(IDX_CAR, 8'h42);
        wr(IDX_ICCSR, 8'h1c);
        i_pat_pins_model.set_pin(0, 1'b1);
        i_pat_pins_model.set_pin(1, 1'b1);
        chk("capture irq", 32'h1, {30'h0, capture_irq});
        wr(IDX_CAR, 8'h43);
        i_pat_pins_model.set_pin(0, 1'b0);
        i_pat_pins_model.set_pin(0, 1'b1);
        rd(IDX_ICCSR, 8'h1d, "capture flags");
        rd(IDX_ICR1, 8'h42, "capture one");
        rd(IDX_ICCSR, 8'h1c, "flags after read");
        halt_mode <= 1'b1;
        i_pat_pins_model.set_pin(1, 1'b0);
        repeat (2) @(posedge clock);
        chk("wake", 32'h1, {31'h0, wake_req});
        chk("capture irq two", 32'h2, {30'h0, capture_irq});
        rd(IDX_ICR2, 8'h43, "capture two");
        print_verdict();
    end
endmodule
